// ==== shared/sgrc_pkg.sv ====
// Constants shared by the start guard and trip reset control block.
package sgrc_pkg;
  // Input function codes that may be assigned to a general-purpose input.
  localparam logic [7:0] SGRC_FN_START_GUARD = 8'h0D;
  localparam logic [7:0] SGRC_FN_BYPASS      = 8'h0E;
  localparam logic [7:0] SGRC_FN_TRIP_RESET  = 8'h12;
  // The bypass function is honoured only on inputs numbered 1 through this value.
  localparam int         SGRC_BYPASS_MAX_IN  = 7;
  // Error codes shown on the error code output.
  localparam logic [7:0] SGRC_ERR_NONE       = 8'h00;
  localparam logic [7:0] SGRC_ERR_GUARD      = 8'h13;
  localparam logic [7:0] SGRC_ERR_UNDERVOLT  = 8'h09;
  // Timing: clock rate and the one millisecond tick used for the retry wait.
  localparam int         SGRC_CLK_MHZ        = 40;
  localparam int         SGRC_TICK_US        = 1000;
  localparam int         SGRC_TICK_CYCLES    = SGRC_CLK_MHZ * SGRC_TICK_US;
  // Cycles after reset release before the pins are trusted (two sync stages plus edge stage).
  localparam int         SGRC_SETTLE_CYCLES  = 3;
  localparam int         SGRC_SETTLE_W       = 2;
  localparam int         SGRC_FN_W           = 8;
endpackage

// ==== verilog/sgrc_ctrl.sv ====
// Run, start guard, line bypass and trip reset control of the motor drive.
`timescale 1ns/1ps
`default_nettype none
module sgrc_ctrl
  import sgrc_pkg::*;
#(
  parameter int N_IN        = 7,
  parameter int TICK_CYCLES = SGRC_TICK_CYCLES,
  parameter int RETRY_W     = 16,
  parameter int FREQ_W      = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   forward_run_cmd,
  input  wire logic                   reverse_run_cmd,
  input  wire logic [N_IN-1:0]        gp_in,
  input  wire logic                   keypad_reset,
  input  wire logic                   undervoltage,
  input  wire logic [N_IN*SGRC_FN_W-1:0] fn_code,
  input  wire logic [N_IN-1:0]        fn_invert,
  input  wire logic [RETRY_W-1:0]     retry_wait_ms,
  input  wire logic [FREQ_W-1:0]      speed_est,
  input  wire logic [FREQ_W-1:0]      base_freq,
  output logic                        motor_run,
  output logic                        alarm,
  output logic [7:0]                  error_code,
  output logic                        match_start,
  output logic                        zero_start
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  generate
    if (N_IN < 1 || N_IN > 8) begin : g_bad_n_in
      $error("N_IN must be between 1 and 8");
    end
    if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 1");
    end
    if (RETRY_W < 1 || FREQ_W < 1) begin : g_bad_width
      $error("RETRY_W and FREQ_W must be at least 1");
    end
  endgenerate

  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_STOP,
    ST_RUN,
    ST_GUARD_TRIP,
    ST_UV_TRIP,
    ST_RESET_HOLD,
    ST_BYPASS,
    ST_RETRY,
    ST_MATCH
  } sgrc_state_type;

  typedef struct packed {
    sgrc_state_type             st;
    logic [N_IN-1:0]            gp_m;
    logic [N_IN-1:0]            gp_s;
    logic [1:0]                 run_m;
    logic [1:0]                 run_s;
    logic                       key_m;
    logic                       key_s;
    logic                       uv_m;
    logic                       uv_s;
    logic                       rs_prev;
    logic                       byp_prev;
    logic                       key_prev;
    logic                       prev_guard;
    logic [SGRC_SETTLE_W-1:0]   settle;
    logic [TICK_W-1:0]          tick;
    logic [RETRY_W-1:0]         wait_ms;
    logic                       motor;
    logic                       alarm;
    logic [7:0]                 code;
    logic                       match_start;
    logic                       zero_start;
  } sgrc_regs_type;

  sgrc_regs_type q;
  sgrc_regs_type d;

  // True when any input assigned the given function is active, up to a highest input number.
  function automatic logic fn_hit(input logic [N_IN*SGRC_FN_W-1:0] codes,
                                  input logic [N_IN-1:0] lvls,
                                  input logic [7:0] fn,
                                  input int max_in);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (i < max_in && codes[i*SGRC_FN_W +: SGRC_FN_W] == fn && lvls[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic [N_IN-1:0] lvl;
  logic            run_now;
  logic            guard_now;
  logic            rs_now;
  logic            byp_now;
  logic            rs_fall;
  logic            byp_rise;
  logic            byp_fall;
  logic            key_rise;
  logic            slow_motor;

  // Inversion is ignored for the trip-reset function, so it is always normally open.
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      lvl[i] = q.gp_s[i] ^ (fn_invert[i] &&
               fn_code[i*SGRC_FN_W +: SGRC_FN_W] != SGRC_FN_TRIP_RESET);
    end
  end

  assign run_now    = |q.run_s;
  assign guard_now  = fn_hit(fn_code, lvl, SGRC_FN_START_GUARD, N_IN);
  assign rs_now     = fn_hit(fn_code, lvl, SGRC_FN_TRIP_RESET, N_IN);
  assign byp_now    = fn_hit(fn_code, lvl, SGRC_FN_BYPASS, SGRC_BYPASS_MAX_IN);
  // Edges are taken only from synchronised levels, never from the first stage.
  assign rs_fall    = q.rs_prev && !rs_now;
  assign byp_rise   = !q.byp_prev && byp_now;
  assign byp_fall   = q.byp_prev && !byp_now;
  assign key_rise   = !q.key_prev && q.key_s;
  assign slow_motor = speed_est <= (base_freq >> 1);

  always_comb begin
    d             = q;
    d.gp_m        = gp_in;
    d.gp_s        = q.gp_m;
    d.run_m       = {reverse_run_cmd, forward_run_cmd};
    d.run_s       = q.run_m;
    d.key_m       = keypad_reset;
    d.key_s       = q.key_m;
    d.uv_m        = undervoltage;
    d.uv_s        = q.uv_m;
    d.rs_prev     = rs_now;
    d.byp_prev    = byp_now;
    d.key_prev    = q.key_s;
    d.match_start = 1'b0;
    d.zero_start  = 1'b0;
    if (q.tick != '0) begin
      d.tick = q.tick - TICK_W'(1);
    end
    // The trip-reset level overrides everything except the power-up check.
    if (q.st != ST_PWRUP && rs_now) begin
      if (q.st != ST_RESET_HOLD) begin
        d.prev_guard = (q.st == ST_GUARD_TRIP);
      end
      d.st = ST_RESET_HOLD;
    end else begin
      case (q.st)
        ST_PWRUP: begin
          if (q.settle != '0) begin
            d.settle = q.settle - SGRC_SETTLE_W'(1);
          end else if (run_now && guard_now) begin
            d.st = ST_GUARD_TRIP;
          end else if (run_now) begin
            d.st = ST_RUN;
          end else begin
            d.st = ST_STOP;
          end
        end
        ST_STOP: begin
          if (q.uv_s) begin
            d.st = ST_UV_TRIP;
          end else if (byp_rise) begin
            d.st = ST_BYPASS;
          end else if (run_now) begin
            d.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (q.uv_s) begin
            d.st = ST_UV_TRIP;
          end else if (byp_rise) begin
            d.st = ST_BYPASS;
          end else if (!run_now) begin
            d.st = ST_STOP;
          end
        end
        ST_GUARD_TRIP: begin
          if (!run_now) begin
            d.st = ST_STOP;
          end else if (key_rise) begin
            d.st = ST_RUN;
          end
        end
        ST_UV_TRIP: begin
          // A keypad reset behaves as a power-up reset, so the guard check runs again.
          if (key_rise) begin
            d.st     = ST_PWRUP;
            d.settle = '0;
          end
        end
        ST_RESET_HOLD: begin
          if (rs_fall) begin
            if (q.prev_guard) begin
              d.st = run_now ? ST_RUN : ST_STOP;
            end else begin
              d.st     = ST_PWRUP;
              d.settle = '0;
            end
            d.prev_guard = 1'b0;
          end
        end
        ST_BYPASS: begin
          if (q.uv_s) begin
            d.st = ST_UV_TRIP;
          end else if (byp_fall && run_now) begin
            d.st      = ST_RETRY;
            d.wait_ms = retry_wait_ms;
            d.tick    = TICK_W'(TICK_CYCLES);
          end else if (byp_fall) begin
            d.st = ST_STOP;
          end
        end
        ST_RETRY: begin
          if (q.uv_s) begin
            d.st = ST_UV_TRIP;
          end else if (!run_now) begin
            d.st = ST_STOP;
          end else if (q.wait_ms == '0) begin
            d.st = ST_MATCH;
          end else if (q.tick == '0) begin
            d.wait_ms = q.wait_ms - RETRY_W'(1);
            d.tick    = TICK_W'(TICK_CYCLES);
          end
        end
        ST_MATCH: begin
          d.st = ST_RUN;
          if (slow_motor) begin
            d.zero_start = 1'b1;
          end else begin
            d.match_start = 1'b1;
          end
        end
        default: begin
          d.st = ST_PWRUP;
        end
      endcase
    end
    d.motor = (d.st == ST_RUN);
    d.alarm = (d.st == ST_GUARD_TRIP) || (d.st == ST_UV_TRIP);
    case (d.st)
      ST_GUARD_TRIP: d.code = SGRC_ERR_GUARD;
      ST_UV_TRIP:    d.code = SGRC_ERR_UNDERVOLT;
      default:       d.code = SGRC_ERR_NONE;
    endcase
  end

  // Reset is the power-up reset: it waits for the synchronisers before checking run.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      q        <= '0;
      q.st     <= ST_PWRUP;
      q.settle <= SGRC_SETTLE_W'(SGRC_SETTLE_CYCLES);
      q.code   <= SGRC_ERR_NONE;
    end else begin
      q <= d;
    end
  end

  assign motor_run   = q.motor;
  assign alarm       = q.alarm;
  assign error_code  = q.code;
  assign match_start = q.match_start;
  assign zero_start  = q.zero_start;

  logic pwr_check;
  assign pwr_check = (q.st == ST_PWRUP) && (q.settle == '0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_plain_start_run:   assert property (pwr_check && run_now && !guard_now |=> motor_run)
    else $error("run at power-up without guard did not start");
  a_guard_keeps_off:   assert property (pwr_check && run_now && guard_now |=> !motor_run [*2])
    else $error("guard let the motor start at power-up");
  a_guard_trip_alarm:  assert property (pwr_check && run_now && guard_now
                                        |=> alarm && error_code == SGRC_ERR_GUARD)
    else $error("guard trip did not show alarm and code");
  a_guard_run_clear:   assert property (q.st == ST_GUARD_TRIP && !run_now && !rs_now |=> !alarm)
    else $error("guard alarm stayed after run removal");
  a_rerun_starts:      assert property (q.st == ST_STOP && run_now && !rs_now && !q.uv_s && !byp_rise
                                        |=> motor_run)
    else $error("run after stop did not start");
  a_reset_restart:     assert property (q.st == ST_RESET_HOLD && rs_fall && q.prev_guard && run_now
                                        |=> motor_run)
    else $error("guard reset with run active did not restart");
  a_uv_guard_check:    assert property (q.st == ST_RESET_HOLD && rs_fall && !q.prev_guard
                                        |=> q.st == ST_PWRUP && q.settle == '0)
    else $error("undervoltage reset skipped the guard check");
  a_reset_forces_off:  assert property (q.st != ST_PWRUP && rs_now |=> !motor_run && !alarm)
    else $error("trip-reset input did not force output off");
  a_bypass_retry:      assert property (q.st == ST_BYPASS && byp_fall && run_now && !rs_now && !q.uv_s
                                        |=> q.st == ST_RETRY && !motor_run)
    else $error("bypass release did not enter retry wait");
  a_zero_start:        assert property (q.st == ST_MATCH && !rs_now && slow_motor
                                        |=> zero_start && motor_run && !match_start)
    else $error("slow motor did not start from zero");

  c_guard_trip:    cover property (pwr_check && run_now && guard_now ##1 alarm);
  c_bypass_resume: cover property (q.st == ST_RETRY ##[1:1000] match_start);
  c_reset_pulse:   cover property (q.st == ST_RESET_HOLD && rs_fall ##1 motor_run);
  c_uv_trip:       cover property (q.st == ST_RUN ##1 q.st == ST_UV_TRIP);

endmodule
`default_nettype wire

// ==== test/sgrc_host_model.sv ====
// Behavioural model of the machine controller that drives the run and function pins.
`timescale 1ns/1ps
`default_nettype none
module sgrc_host_model (
  input  wire logic       clk,
  output logic            forward_run_cmd,
  output logic            reverse_run_cmd,
  output logic [6:0]      gp_in,
  output logic            keypad_reset,
  output logic            undervoltage
);
  initial begin
    forward_run_cmd = 1'b0;
    reverse_run_cmd = 1'b0;
    gp_in = 7'h00;
    keypad_reset = 1'b0;
    undervoltage = 1'b0;
  end
  // Pins move only at the falling edge, so the block never samples a level in motion.
  task automatic set_run(input logic fw, input logic rv);
    @(negedge clk);
    forward_run_cmd = fw;
    reverse_run_cmd = rv;
  endtask
  task automatic set_gp(input int idx, input logic v);
    @(negedge clk);
    gp_in[idx] = v;
  endtask
  // The key is held three cycles because shorter presses may slip between samples.
  task automatic press_key();
    @(negedge clk);
    keypad_reset = 1'b1;
    repeat (3) @(negedge clk);
    keypad_reset = 1'b0;
  endtask
  task automatic set_uv(input logic v);
    @(negedge clk);
    undervoltage = v;
  endtask
endmodule
`default_nettype wire

// ==== test/sgrc_ctrl_test.sv ====
// Self-checking testbench of the start guard and trip reset control block.
`timescale 1ns/1ps
`default_nettype none
module sgrc_ctrl_test;
  import sgrc_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  wire logic   fw;
  wire logic   rv;
  wire logic   kp;
  wire logic   uv;
  wire logic [6:0] gp;
  logic [55:0] fn_code = {32'h0000_0000, SGRC_FN_TRIP_RESET, SGRC_FN_BYPASS, SGRC_FN_START_GUARD};
  // Inverting the trip reset input must have no effect on it.
  logic [6:0]  fn_invert = 7'h04;
  logic [15:0] retry_ms = 16'h0002;
  logic [15:0] speed = 16'h0000;
  logic [15:0] base = 16'h0064;
  logic        motor_run;
  logic        alarm;
  logic [7:0]  error_code;
  logic        match_start;
  logic        zero_start;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #12.5 clk = ~clk;
  sgrc_host_model host (.clk(clk), .forward_run_cmd(fw), .reverse_run_cmd(rv), .gp_in(gp),
    .keypad_reset(kp), .undervoltage(uv));
  sgrc_ctrl #(.N_IN(7), .TICK_CYCLES(4)) dut (.clk(clk), .rstn(rstn), .forward_run_cmd(fw),
    .reverse_run_cmd(rv), .gp_in(gp), .keypad_reset(kp), .undervoltage(uv), .fn_code(fn_code),
    .fn_invert(fn_invert), .retry_wait_ms(retry_ms), .speed_est(speed), .base_freq(base),
    .motor_run(motor_run), .alarm(alarm), .error_code(error_code), .match_start(match_start),
    .zero_start(zero_start));
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic expect_out(input logic m, input logic a, input logic [7:0] e);
    check({15'h0000, motor_run}, {15'h0000, m});
    check({15'h0000, alarm}, {15'h0000, a});
    check({8'h00, error_code}, {8'h00, e});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Pins settle before reset ends, so the power-up decision sees stable levels.
  task automatic power_up(input logic f, input logic r, input logic guard);
    host.set_run(f, r);
    host.set_gp(0, guard);
    rstn = 1'b0;
    wait_cyc(8);
    rstn = 1'b1;
    wait_cyc(8);
  endtask
  task automatic s_plain_start();
    power_up(1'b0, 1'b1, 1'b0);
    expect_out(1'b1, 1'b0, SGRC_ERR_NONE);
    // A normally closed guard input counts as ON while its pin is low.
    fn_invert = 7'h05;
    power_up(1'b1, 1'b0, 1'b0);
    expect_out(1'b0, 1'b1, SGRC_ERR_GUARD);
    fn_invert = 7'h04;
  endtask
  task automatic s_guard_clear();
    power_up(1'b1, 1'b0, 1'b1);
    expect_out(1'b0, 1'b1, SGRC_ERR_GUARD);
    host.set_run(1'b0, 1'b0);
    wait_cyc(5);
    expect_out(1'b0, 1'b0, SGRC_ERR_NONE);
    host.set_run(1'b1, 1'b0);
    wait_cyc(5);
    expect_out(1'b1, 1'b0, SGRC_ERR_NONE);
  endtask
  task automatic s_reset_pin();
    power_up(1'b1, 1'b0, 1'b1);
    host.set_gp(2, 1'b1);
    wait_cyc(5);
    expect_out(1'b0, 1'b0, SGRC_ERR_NONE);
    host.set_gp(2, 1'b0);
    wait_cyc(5);
    expect_out(1'b1, 1'b0, SGRC_ERR_NONE);
    host.set_gp(2, 1'b1);
    wait_cyc(4);
    host.set_gp(2, 1'b0);
    wait_cyc(8);
    expect_out(1'b0, 1'b1, SGRC_ERR_GUARD);
  endtask
  task automatic s_keypad();
    power_up(1'b1, 1'b0, 1'b1);
    host.press_key();
    wait_cyc(5);
    expect_out(1'b1, 1'b0, SGRC_ERR_NONE);
    host.press_key();
    wait_cyc(5);
    expect_out(1'b1, 1'b0, SGRC_ERR_NONE);
  endtask
  task automatic s_undervolt();
    power_up(1'b1, 1'b0, 1'b0);
    host.set_gp(0, 1'b1);
    host.set_uv(1'b1);
    wait_cyc(5);
    host.set_uv(1'b0);
    wait_cyc(5);
    expect_out(1'b0, 1'b1, SGRC_ERR_UNDERVOLT);
    host.set_gp(2, 1'b1);
    wait_cyc(4);
    host.set_gp(2, 1'b0);
    wait_cyc(8);
    expect_out(1'b0, 1'b1, SGRC_ERR_GUARD);
    // The keypad reset of an undervoltage trip runs the guard check as well.
    host.set_run(1'b0, 1'b0);
    wait_cyc(5);
    host.set_run(1'b1, 1'b0);
    host.set_uv(1'b1);
    wait_cyc(5);
    expect_out(1'b0, 1'b1, SGRC_ERR_UNDERVOLT);
    host.set_uv(1'b0);
    host.press_key();
    wait_cyc(8);
    expect_out(1'b0, 1'b1, SGRC_ERR_GUARD);
  endtask
  // Slow motor restarts from zero, fast motor is caught by frequency matching.
  task automatic s_bypass();
    logic ms;
    logic zs;
    power_up(1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      speed = (k == 0) ? 16'h0032 : 16'h0033;
      host.set_gp(1, 1'b1);
      wait_cyc(5);
      expect_out(1'b0, 1'b0, SGRC_ERR_NONE);
      host.set_gp(1, 1'b0);
      ms = 1'b0;
      zs = 1'b0;
      for (int i = 0; i < 60 && !(ms === 1'b1 || zs === 1'b1); i++) begin
        @(posedge clk);
        #1;
        ms = match_start;
        zs = zero_start;
      end
      check({15'h0000, zs}, (k == 0) ? 16'h0001 : 16'h0000);
      check({15'h0000, ms}, (k == 0) ? 16'h0000 : 16'h0001);
      wait_cyc(2);
      expect_out(1'b1, 1'b0, SGRC_ERR_NONE);
    end
  endtask
  initial begin
    s_plain_start();
    s_guard_clear();
    s_reset_pin();
    s_keypad();
    s_undervolt();
    s_bypass();
    summarize();
  end
endmodule
`default_nettype wire
